/* File: src/otp_prog_pkg.sv */
// Types shared by the PROM programmer modules.
// Assumes otp_prog_regs.svh is on the include path.
`include "otp_prog_regs.svh"
package otp_prog_pkg;
    typedef enum logic [1:0] {CMD_PAGE_WRITE, CMD_BYTE_WRITE, CMD_READ} cmd_type;

    // Request word from the user side
    typedef struct packed {
        cmd_type cmd;
        logic [`OTP_ADDR_W-1:0] addr;
        logic [31:0] data;
    } req_type;

    // Answer word to the user side
    typedef struct packed {
        logic ok;
        logic [3:0] tries;
        logic [31:0] data;
    } rsp_type;
endpackage

/* File: src/otp_prog_regs.svh */
// Constants for the one-time PROM programmer: timing counts, page layout, limits.
// Assumes a 20 MHz system clock; included by the package, the programmer and the bench.
// Notes on behaviour
// - Device needs reset low and high programming supply
// - Full page then 0.1 ms program pulse
// - Verify page after each write pulse
// - Retry write and verify, ten attempts maximum
// - Byte write: enable low, 0.1 ms pulse
// - Verify byte by lowering read strobe
// - Shared bus: strobe only the selected device
// - Address settles before strobe falls; in page verify S_GAP moves it as enable falls or while it is low
`ifndef OTP_PROG_REGS_SVH
`define OTP_PROG_REGS_SVH

`define OTP_CLK_HZ 20000000
`define OTP_PULSE_NS 100000
`define OTP_PULSE_CYC ((`OTP_PULSE_NS * (`OTP_CLK_HZ / 1000000) + 999) / 1000)
`define OTP_SETUP_CYC 2
`define OTP_SAMPLE_CYC 3
`define OTP_PAGE_BYTES 4
`define OTP_MAX_TRIES 10
`define OTP_ARRAY_BYTES 63488
`define OTP_ADDR_W 17

`endif

/* File: src/otp_prom_programmer.sv */
// Host-side programmer for a one-time PROM programming port.
// Assumes the device already sits in programming mode: reset held low and the
// programming supply raised by board logic outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "otp_prog_regs.svh"
module otp_prom_programmer #(
    parameter int PULSE_CYC = `OTP_PULSE_CYC,
    parameter int MAX_TRIES = `OTP_MAX_TRIES
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Request side
    input wire logic I_REQ_VALID,
    output logic O_REQ_READY,
    input wire otp_prog_pkg::req_type I_REQ,
    // Answer side
    output logic O_RSP_VALID,
    input wire logic I_RSP_READY,
    output otp_prog_pkg::rsp_type O_RSP,
    // Device pins
    output logic [`OTP_ADDR_W-1:0] O_PROM_ADDRESS,
    output logic [7:0] O_PROM_DATA_BUS,
    output logic O_PROM_DATA_BUS_OE_N,
    input wire logic [7:0] I_PROM_DATA_BUS,
    output logic O_PROM_ENABLE_N,
    output logic O_READ_STROBE_N,
    output logic O_PROGRAM_PULSE_N,
    output logic O_BUSY
);
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_LATCH, S_PULSE, S_GAP, S_VERIFY, S_NEXT, S_ANSWER
    } state_type;

    localparam logic [15:0] SETUP_CYC = 16'(`OTP_SETUP_CYC);
    localparam logic [15:0] SAMPLE_CYC = 16'(`OTP_SAMPLE_CYC);
    localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYC);
    localparam logic [3:0] TRY_LIMIT = 4'(MAX_TRIES);

    initial
    begin
        if (PULSE_CYC < 1 || PULSE_CYC > 65535)
        begin
            $error("PULSE_CYC out of range");
        end
        if (MAX_TRIES < 1 || MAX_TRIES > 15)
        begin
            $error("MAX_TRIES out of range");
        end
    end

    // ========================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ========================================================
    // Data pin synchroniser
    logic [7:0] din_meta_q;
    logic [7:0] din_q;
    always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            din_meta_q <= 8'h00;
            din_q <= 8'h00;
        end
        else
        begin
            din_meta_q <= I_PROM_DATA_BUS;
            din_q <= din_meta_q;
        end
    end

    // ========================================================
    // Sequencer
    state_type state_q;
    otp_prog_pkg::req_type req_q;
    logic [15:0] cnt_q;
    logic [1:0] idx_q;
    logic [3:0] tries_q;
    logic [31:0] rdata_q;
    logic mism_q;
    logic ok_q;
    logic rsp_push;
    logic rsp_ready;
    logic [7:0] want;

    assign want = req_q.data[8*idx_q +: 8];
    assign rsp_push = (state_q == S_ANSWER);

    always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= S_IDLE;
            req_q <= '0;
            cnt_q <= 16'h0000;
            idx_q <= 2'h0;
            tries_q <= 4'h0;
            rdata_q <= 32'h00000000;
            mism_q <= 1'b0;
            ok_q <= 1'b0;
            O_REQ_READY <= 1'b0;
            O_BUSY <= 1'b0;
            O_PROM_ADDRESS <= '0;
            O_PROM_DATA_BUS <= 8'h00;
            O_PROM_DATA_BUS_OE_N <= 1'b1;
            O_PROM_ENABLE_N <= 1'b1;
            O_READ_STROBE_N <= 1'b1;
            O_PROGRAM_PULSE_N <= 1'b1;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    O_REQ_READY <= 1'b1;
                    O_PROM_ENABLE_N <= 1'b1;
                    O_READ_STROBE_N <= 1'b1;
                    O_PROM_DATA_BUS_OE_N <= 1'b1;
                    if (I_REQ_VALID && O_REQ_READY)
                    begin
                        O_REQ_READY <= 1'b0;
                        O_BUSY <= 1'b1;
                        req_q <= I_REQ;
                        if (I_REQ.cmd == otp_prog_pkg::CMD_PAGE_WRITE)
                        begin
                            // Page base is forced to an aligned boundary
                            req_q.addr[1:0] <= 2'h0;
                        end
                        idx_q <= 2'h0;
                        tries_q <= 4'h0;
                        mism_q <= 1'b0;
                        cnt_q <= 16'h0000;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    // Address and data settle before any strobe moves
                    O_PROM_ADDRESS <= req_q.addr | `OTP_ADDR_W'(idx_q);
                    O_PROM_DATA_BUS <= want;
                    O_PROM_DATA_BUS_OE_N <= (req_q.cmd == otp_prog_pkg::CMD_READ);
                    O_PROM_ENABLE_N <= (req_q.cmd == otp_prog_pkg::CMD_PAGE_WRITE)
                        || (cnt_q == 16'h0000);
                    O_READ_STROBE_N <= 1'b1;
                    cnt_q <= 16'(cnt_q + 16'h0001);
                    if (cnt_q + 16'h0001 >= SETUP_CYC)
                    begin
                        cnt_q <= 16'h0000;
                        if (req_q.cmd == otp_prog_pkg::CMD_PAGE_WRITE)
                        begin
                            state_q <= S_LATCH;
                        end
                        else if (req_q.cmd == otp_prog_pkg::CMD_BYTE_WRITE)
                        begin
                            state_q <= S_PULSE;
                        end
                        else
                        begin
                            state_q <= S_VERIFY;
                        end
                    end
                end
                S_LATCH:
                begin
                    O_READ_STROBE_N <= 1'b0;
                    cnt_q <= 16'(cnt_q + 16'h0001);
                    if (cnt_q + 16'h0001 >= SETUP_CYC)
                    begin
                        cnt_q <= 16'h0000;
                        O_READ_STROBE_N <= 1'b1;
                        idx_q <= 2'(idx_q + 2'h1);
                        state_q <= (idx_q == 2'h3) ? S_PULSE : S_SETUP;
                        if (idx_q == 2'h3)
                        begin
                            O_PROM_DATA_BUS_OE_N <= 1'b1;
                            O_PROM_ENABLE_N <= 1'b1;
                        end
                    end
                end
                S_PULSE:
                begin
                    O_PROGRAM_PULSE_N <= 1'b0;
                    cnt_q <= 16'(cnt_q + 16'h0001);
                    if (cnt_q >= PULSE_LEN) // Low for exactly PULSE_LEN cycles
                    begin
                        O_PROGRAM_PULSE_N <= 1'b1;
                        O_PROM_DATA_BUS_OE_N <= 1'b1;
                        tries_q <= 4'(tries_q + 4'h1);
                        idx_q <= 2'h0;
                        mism_q <= 1'b0;
                        cnt_q <= 16'h0000;
                        state_q <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    // Bus released one setup time before the device drives it
                    O_PROM_ADDRESS <= req_q.addr | `OTP_ADDR_W'(idx_q);
                    O_PROM_ENABLE_N <= 1'b0;
                    cnt_q <= 16'(cnt_q + 16'h0001);
                    if (cnt_q + 16'h0001 >= SETUP_CYC)
                    begin
                        cnt_q <= 16'h0000;
                        state_q <= S_VERIFY;
                    end
                end
                S_VERIFY:
                begin
                    // Only this device's strobe is driven on a shared bus
                    O_PROM_ENABLE_N <= 1'b0;
                    O_READ_STROBE_N <= 1'b0;
                    cnt_q <= 16'(cnt_q + 16'h0001);
                    // Sampling waits out the two-stage data synchroniser
                    if (cnt_q >= SAMPLE_CYC + 16'h0002)
                    begin
                        cnt_q <= 16'h0000;
                        O_READ_STROBE_N <= 1'b1;
                        rdata_q[8*idx_q +: 8] <= din_q;
                        if (din_q != want)
                        begin
                            mism_q <= 1'b1;
                        end
                        state_q <= S_NEXT;
                    end
                end
                S_NEXT:
                begin
                    if (req_q.cmd == otp_prog_pkg::CMD_PAGE_WRITE && idx_q != 2'h3)
                    begin
                        idx_q <= 2'(idx_q + 2'h1);
                        state_q <= S_GAP;
                    end
                    else if (req_q.cmd == otp_prog_pkg::CMD_READ || !mism_q)
                    begin
                        ok_q <= 1'b1;
                        state_q <= S_ANSWER;
                    end
                    else if (tries_q >= TRY_LIMIT)
                    begin
                        ok_q <= 1'b0;
                        state_q <= S_ANSWER;
                    end
                    else
                    begin
                        // Retry: the page latch still holds the data
                        O_PROM_ENABLE_N <= (req_q.cmd == otp_prog_pkg::CMD_PAGE_WRITE);
                        O_PROM_DATA_BUS <= req_q.data[7:0];
                        O_PROM_ADDRESS <= req_q.addr;
                        O_PROM_DATA_BUS_OE_N <= (req_q.cmd == otp_prog_pkg::CMD_PAGE_WRITE);
                        state_q <= S_PULSE;
                    end
                end
                S_ANSWER:
                begin
                    O_PROM_ENABLE_N <= 1'b1;
                    if (rsp_ready)
                    begin
                        O_BUSY <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Answer buffer; the user may stall without losing a word
    otp_prog_pkg::rsp_type rsp_in;
    otp_prog_pkg::rsp_type rsp_out;
    logic rsp_valid;
    assign rsp_in = '{ok: ok_q, tries: tries_q, data: rdata_q};

    otp_skid_buf #(
        .WIDTH($bits(otp_prog_pkg::rsp_type))
    ) u_rsp_buf (
        .clk(I_CLK_SYS),
        .rst_n(rst_n_q),
        .in_valid(rsp_push),
        .in_ready(rsp_ready),
        .in_data(rsp_in),
        .out_valid(rsp_valid),
        .out_ready(I_RSP_READY),
        .out_data(rsp_out)
    );

    assign O_RSP_VALID = rsp_valid;
    assign O_RSP = rsp_out;
endmodule // otp_prom_programmer
`default_nettype wire

/* File: src/otp_skid_buf.sv */
// Two-entry valid/ready buffer for answer words.
// Assumes one clock and a synchronous reset copy from the parent.
`timescale 1ns/10ps
`default_nettype none
module otp_skid_buf #(
    parameter int WIDTH = 37
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic [1:0] cnt_q;
    logic wr_q;
    logic rd_q;
    logic push;
    logic pop;
    logic [1:0] cnt_d;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("WIDTH must be positive");
        end
    end

    assign in_ready = (cnt_q != 2'h2);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 2'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_d;
            out_valid <= (cnt_d != 2'h0);
        end
    end

    // Head word has its own register so the answer leaves straight from a flop
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
        if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
        begin
            out_data <= in_data;
        end
        else if (pop)
        begin
            out_data <= mem_q[~rd_q];
        end
    end
endmodule // otp_skid_buf
`default_nettype wire

/* File: verification/otp_prom_device.sv */
// Behavioural model of the PROM in programming mode, seen at its pins.
// Assumes supply and reset already select programming mode; miss is set by the bench.
`timescale 1ns/10ps
`default_nettype none
module otp_prom_device (
    // Pins from the programmer
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_enable_n,
    input wire logic i_read_n,
    input wire logic i_pulse_n,
    // Data driven back
    output logic [7:0] o_data
);
    logic [7:0] mem [0:63487];
    logic [7:0] page [0:3];
    logic [14:0] base;
    logic [16:0] wa;
    logic [7:0] wd;
    logic wpage;
    int miss;
    initial
    begin
        miss = 0;
        foreach (mem[i])
            mem[i] = 8'hFF;
    end
    // Released bus shows the inverse, so a stale value never passes
    assign o_data = (!i_enable_n && !i_read_n) ? mem[i_addr] : ~mem[i_addr];
    always @*
        if (i_enable_n && !i_read_n && i_pulse_n)
        begin
            page[i_addr[1:0]] = i_data;
            base = i_addr[16:2];
        end
    always @(negedge i_pulse_n)
    begin
        wa = i_addr;
        wd = i_data;
        wpage = i_enable_n;
    end
    // Commit at pulse end; miss makes the next pulses leave the array untouched
    always @(posedge i_pulse_n)
        if (miss > 0)
            miss--;
        else if (wpage === 1'b1)
            for (int i = 0; i < 4; i++)
                mem[{base, 2'(i)}] = page[i];
        else if (wpage === 1'b0)
            mem[wa] = wd;
endmodule // otp_prom_device
`default_nettype wire

/* File: verification/otp_prom_programmer_bench.sv */
// Self-checking bench for the PROM programmer against the device model.
// Assumes otp_prog_regs.svh on the include path; short pulse count for speed.
`timescale 1ns/10ps
`default_nettype none
`include "otp_prog_regs.svh"
module otp_prom_programmer_bench;
    localparam int PULSE = 4;
    localparam otp_prog_pkg::cmd_type BW = otp_prog_pkg::CMD_BYTE_WRITE;
    localparam otp_prog_pkg::cmd_type PW = otp_prog_pkg::CMD_PAGE_WRITE;
    localparam otp_prog_pkg::cmd_type RD = otp_prog_pkg::CMD_READ;
    typedef struct {
        otp_prog_pkg::cmd_type c;
        logic [16:0] a;
        logic [31:0] d;
        logic [3:0] miss;
        logic ok;
        logic [3:0] t;
        logic [31:0] x;
    } row_type;
    row_type rows [13] = '{
        '{BW, 17'h00010, 32'hAA, 4'h0, 1'h1, 4'h1, 32'h0},
        '{RD, 17'h00010, 32'h0, 4'h0, 1'h1, 4'h1, 32'hAA},
        '{PW, 17'h00020, 32'h44332211, 4'h2, 1'h1, 4'h3, 32'h44332211},
        '{RD, 17'h00023, 32'h0, 4'h0, 1'h1, 4'h1, 32'h44},
        '{RD, 17'h00021, 32'h0, 4'h0, 1'h1, 4'h1, 32'h22},
        '{PW, 17'h00046, 32'hDDCCBBAA, 4'h0, 1'h1, 4'h1, 32'hDDCCBBAA},
        '{RD, 17'h00044, 32'h0, 4'h0, 1'h1, 4'h1, 32'hAA},
        '{RD, 17'h00047, 32'h0, 4'h0, 1'h1, 4'h1, 32'hDD},
        '{BW, 17'h0F7FF, 32'h5A, 4'h0, 1'h1, 4'h1, 32'h0},
        '{RD, 17'h0F7FF, 32'h0, 4'h0, 1'h1, 4'h1, 32'h5A},
        '{BW, 17'h00050, 32'h0F, 4'hA, 1'h0, 4'hA, 32'h0},
        '{RD, 17'h00050, 32'h0, 4'h0, 1'h1, 4'h1, 32'hFF},
        '{RD, 17'h00030, 32'h0, 4'h0, 1'h1, 4'h1, 32'hFF}
    };
    logic clk, rst_n, req_valid, req_ready, rsp_valid, rsp_ready;
    logic oe_n, en_n, rd_n, prog_n, busy;
    logic [16:0] addr;
    logic [7:0] hdata, ddata, bus;
    otp_prog_pkg::req_type req;
    otp_prog_pkg::rsp_type rsp, r;
    int err_total, cmp_count;
    assign bus = oe_n ? ddata : hdata;
    otp_prom_programmer #(.PULSE_CYC(PULSE), .MAX_TRIES(`OTP_MAX_TRIES)) uut (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid), .O_REQ_READY(req_ready),
        .I_REQ(req), .O_RSP_VALID(rsp_valid), .I_RSP_READY(rsp_ready), .O_RSP(rsp),
        .O_PROM_ADDRESS(addr), .O_PROM_DATA_BUS(hdata), .O_PROM_DATA_BUS_OE_N(oe_n),
        .I_PROM_DATA_BUS(bus), .O_PROM_ENABLE_N(en_n), .O_READ_STROBE_N(rd_n),
        .O_PROGRAM_PULSE_N(prog_n), .O_BUSY(busy));
    otp_prom_device dev (.i_addr(addr), .i_data(bus), .i_enable_n(en_n), .i_read_n(rd_n),
        .i_pulse_n(prog_n), .o_data(ddata));
    // ==========================================
    // Tasks
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1)
        begin
            tick(1);
            n++;
            if (n > lim)
            begin
                err_total++;
                $display("unexpected wait bound reached");
                end_sim();
            end
        end
    endtask
    task automatic send(input otp_prog_pkg::cmd_type c, input logic [16:0] a, logic [31:0] d);
        req = '{c, a, d};
        req_valid = 1'b1;
        wait_for(req_ready, 100);
        tick(1);
        req_valid = 1'b0;
    endtask
    task automatic take();
        rsp_ready = 1'b1;
        wait_for(rsp_valid, 5000);
        r = rsp;
        tick(1);
        rsp_ready = 1'b0;
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        rsp_ready = 1'b0;
        req = '0;
        err_total = 0;
        cmp_count = 0;
        tick(4);
        chk("idle pins", 32'hF, {28'h0, en_n, rd_n, prog_n, oe_n});
        chk("ready in reset", 32'h0, {31'h0, req_ready});
        tick(4);
        rst_n = 1'b1;
        $display("reset test done");
        foreach (rows[i])
        begin
            dev.miss = rows[i].miss;
            send(rows[i].c, rows[i].a, rows[i].d);
            take();
            tick(1);
            if (rows[i].c == RD)
                chk("read data", {24'h0, rows[i].x[7:0]}, {24'h0, r.data[7:0]});
            else
            begin
                chk("ok and tries", {27'h0, rows[i].ok, rows[i].t}, {27'h0, r.ok, r.tries});
                if (rows[i].c == PW)
                    chk("page verify data", rows[i].x, r.data);
            end
            $display("row %0d done", i);
        end
        // Answers held back: two fill the buffer, the third blocks the sequencer
        send(RD, 17'h00010, 32'h0);
        tick(1);
        send(RD, 17'h0F7FF, 32'h0);
        tick(1);
        send(RD, 17'h00021, 32'h0);
        tick(40);
        chk("ready and busy while stalled", 32'h1, {30'h0, req_ready, busy});
        take();
        chk("first held answer", 32'hAA, {24'h0, r.data[7:0]});
        tick(1);
        take();
        chk("second held answer", 32'h5A, {24'h0, r.data[7:0]});
        tick(1);
        take();
        chk("third held answer", 32'h22, {24'h0, r.data[7:0]});
        $display("buffer test done");
        // Reset cut into a byte pulse: pins go idle, the next read still works
        send(BW, 17'h00060, 32'h33);
        tick(4);
        rst_n = 1'b0;
        tick(2);
        chk("pins in mid reset", 32'h1F, {27'h0, en_n, rd_n, prog_n, oe_n, !busy});
        rst_n = 1'b1;
        send(RD, 17'h00010, 32'h0);
        take();
        chk("read after reset", 32'hAA, {24'h0, r.data[7:0]});
        $display("mid reset test done");
        end_sim();
    end
endmodule // otp_prom_programmer_bench
bind otp_prom_programmer otp_prom_programmer_props #(.PULSE_CYC(PULSE_CYC),
    .MAX_TRIES(MAX_TRIES)) chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
    .O_PROM_ADDRESS(O_PROM_ADDRESS), .O_PROM_DATA_BUS_OE_N(O_PROM_DATA_BUS_OE_N),
    .O_PROM_ENABLE_N(O_PROM_ENABLE_N), .O_READ_STROBE_N(O_READ_STROBE_N),
    .O_PROGRAM_PULSE_N(O_PROGRAM_PULSE_N), .O_BUSY(O_BUSY), .O_RSP_VALID(O_RSP_VALID),
    .O_RSP(O_RSP));
`default_nettype wire

/* File: verification/otp_prom_programmer_props.sv */
// Concurrent checks on the device-side pins and answers of the PROM programmer.
// Bound to otp_prom_programmer from the bench; one clock domain only.
`timescale 1ns/10ps
`default_nettype none
module otp_prom_programmer_props #(
    parameter int PULSE_CYC = 4,
    parameter int MAX_TRIES = 10
) (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // Device pins
    input wire logic [16:0] O_PROM_ADDRESS,
    input wire logic O_PROM_DATA_BUS_OE_N,
    input wire logic O_PROM_ENABLE_N,
    input wire logic O_READ_STROBE_N,
    input wire logic O_PROGRAM_PULSE_N,
    // Status and answer
    input wire logic O_BUSY,
    input wire logic O_RSP_VALID,
    input wire otp_prog_pkg::rsp_type O_RSP
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    // ==========================================
    // Helper counters
    logic [15:0] low_q;
    logic [1:0] lat_q;
    logic oe_q;
    wire lat_ev = oe_q && !O_READ_STROBE_N && O_PROM_ENABLE_N;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N)
            low_q <= 16'h0;
        else
            low_q <= O_PROGRAM_PULSE_N ? 16'h0 : low_q + 16'h1;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N)
            oe_q <= 1'h1;
        else
            oe_q <= O_READ_STROBE_N;
    // Latch index restarts with every request, so a stale count cannot leak
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N)
            lat_q <= 2'h0;
        else if (!O_BUSY)
            lat_q <= 2'h0;
        else if (lat_ev)
            lat_q <= lat_q + 2'h1;
    // ==========================================
    // Properties
    sequence s_verify;
        !O_PROM_ENABLE_N && !O_READ_STROBE_N;
    endsequence
    property p_pulse_len;
        $rose(O_PROGRAM_PULSE_N) |-> low_q == PULSE_CYC;
    endproperty
    property p_pulse_ctl;
        !O_PROGRAM_PULSE_N |-> O_READ_STROBE_N;
    endproperty
    property p_byte_drive;
        !O_PROGRAM_PULSE_N && !O_PROM_ENABLE_N |-> !O_PROM_DATA_BUS_OE_N;
    endproperty
    property p_verify;
        $rose(O_PROGRAM_PULSE_N) |-> ##[1:20] s_verify;
    endproperty
    property p_release;
        s_verify |-> O_PROM_DATA_BUS_OE_N;
    endproperty
    property p_addr;
        !O_READ_STROBE_N |-> $stable(O_PROM_ADDRESS);
    endproperty
    property p_tries;
        O_RSP_VALID && !O_RSP.ok |-> O_RSP.tries == MAX_TRIES;
    endproperty
    property p_align;
        lat_ev |-> O_PROM_ADDRESS[1:0] == lat_q;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("program pulse width differs from the set count");
    a_pulse_ctl: assert property (p_pulse_ctl)
        else $error("read strobe low during program pulse");
    a_byte_drive: assert property (p_byte_drive)
        else $error("byte pulse without data driven");
    a_verify: assert property (p_verify)
        else $error("no verify read after program pulse");
    a_release: assert property (p_release)
        else $error("host drives data bus during device read");
    a_addr: assert property (p_addr)
        else $error("address moved while read strobe low");
    a_tries: assert property (p_tries)
        else $error("failed answer with wrong attempt count");
    a_align: assert property (p_align)
        else $error("page latch address out of order");
endmodule // otp_prom_programmer_props
`default_nettype wire
